// ### host_side_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Processor interrupt input and GPIO line
// ----------------------------------------
module host_side_model (
    input wire logic i_irq,
    input wire logic i_pol_high,
    input wire logic i_gpio_low,
    input wire logic i_pin_out,
    input wire logic i_pin_oe,
    output logic o_pin_level,
    output logic o_irq_seen
);
    // Input sense follows the polarity software programmed
    assign o_irq_seen = i_pol_high ? i_irq : ~i_irq;
    // Pull-up gives high once the device lets go, unless the GPIO pulls low
    assign o_pin_level = i_pin_oe ? i_pin_out : ~i_gpio_low;
endmodule : host_side_model

// ### irq_and_wake_control.sv
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
// Summary of operation
// - Request output asserts only while global interrupt enable is set.
// - Trigger mode bit selects level or pulse signalling.
// - Polarity bit selects active low or high; processor must match.
// - After reset the request is level and active low.
// - Edge pulse width comes from low sixteen bits of edge count.
// - Unprogrammed pulse width is about 500 ns.
// - Top byte of edge count sets minimum spacing; zero means none.
// - Writing one clears a status bit; zero leaves it.
// - Disabled events still set status but raise no request.
// - Request needs global enable and matching individual enable.
// - Level request holds until all enabled set bits are cleared.
// - A started pulse runs full length despite clearing writes.
// - Request logic keeps running while main clocks are stopped.
// - Done bit with its OR mask bit raises that category's request.
// - Otherwise all AND-masked done bits must be set to raise.
// - Bulk time-out holds async completion requests to its interval.
// - Suspend stops main clocks; a slow 100 kHz tick keeps running.
// - Connect change, chip select or low wake pin starts a resume.
// - Wake pin driven low when awake, released in suspend.
// - Resume holds clock-off count; run bit keeps awake, else suspend.
// - Clocks ready event raised after restart; software waits for it.
module irq_and_wake_control (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire irq_wake_pkg::reg_req_t i_bus,
    output logic [31:0] o_read_data,
    input wire logic [31:0] i_events,
    input wire irq_wake_pkg::done_maps_t i_done,
    input wire logic i_port_change,
    input wire logic i_chip_select,
    input wire logic i_run_stop,
    input wire logic i_suspend_request,
    input wire logic i_wake_pin,
    output logic o_wake_pin,
    output logic o_wake_pin_oe,
    output logic o_main_clocks_on,
    output logic o_irq
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [31:0] hw_mode, edge_count, power_down, enable, status, atl_timeout;
    logic [31:0] or_mask [3];
    logic [31:0] and_mask [3];
    logic [31:0] done_map [3];
    logic wr_status;
    logic [31:0] set_vec;

    assign wr_status = i_bus.write && i_bus.address == irq_wake_pkg::REG_STATUS;

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            hw_mode <= irq_wake_pkg::HW_MODE_RESET;
            edge_count <= irq_wake_pkg::EDGE_COUNT_RESET;
            power_down <= irq_wake_pkg::POWER_DOWN_RESET;
            enable <= 32'h0000_0000;
            atl_timeout <= 32'h0000_0000;
            or_mask <= '{default: 32'h0000_0000};
            and_mask <= '{default: 32'h0000_0000};
        end else if (i_bus.write) begin
            unique case (i_bus.address)
                irq_wake_pkg::REG_HW_MODE: hw_mode <= i_bus.write_data;
                irq_wake_pkg::REG_EDGE_COUNT: edge_count <= i_bus.write_data;
                irq_wake_pkg::REG_POWER_DOWN: power_down <= i_bus.write_data;
                irq_wake_pkg::REG_ENABLE: enable <= i_bus.write_data;
                irq_wake_pkg::REG_ATL_TIMEOUT: atl_timeout <= i_bus.write_data;
                irq_wake_pkg::REG_ISO_OR: or_mask[0] <= i_bus.write_data;
                irq_wake_pkg::REG_INT_OR: or_mask[1] <= i_bus.write_data;
                irq_wake_pkg::REG_ATL_OR: or_mask[2] <= i_bus.write_data;
                irq_wake_pkg::REG_ISO_AND: and_mask[0] <= i_bus.write_data;
                irq_wake_pkg::REG_INT_AND: and_mask[1] <= i_bus.write_data;
                irq_wake_pkg::REG_ATL_AND: and_mask[2] <= i_bus.write_data;
                default: ;
            endcase
        end
    end

    // Set beats clear so an event landing on the clearing write is kept
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            status <= 32'h0000_0000;
        end else begin
            status <= (status & ~(wr_status ? i_bus.write_data : 32'h0000_0000)) | set_vec;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            o_read_data <= 32'h0000_0000;
        end else if (i_bus.read) begin
            unique case (i_bus.address)
                irq_wake_pkg::REG_ISO_DONE: o_read_data <= done_map[0];
                irq_wake_pkg::REG_INT_DONE: o_read_data <= done_map[1];
                irq_wake_pkg::REG_ATL_DONE: o_read_data <= done_map[2];
                irq_wake_pkg::REG_HW_MODE: o_read_data <= hw_mode;
                irq_wake_pkg::REG_STATUS: o_read_data <= status;
                irq_wake_pkg::REG_ENABLE: o_read_data <= enable;
                irq_wake_pkg::REG_ISO_OR: o_read_data <= or_mask[0];
                irq_wake_pkg::REG_INT_OR: o_read_data <= or_mask[1];
                irq_wake_pkg::REG_ATL_OR: o_read_data <= or_mask[2];
                irq_wake_pkg::REG_ISO_AND: o_read_data <= and_mask[0];
                irq_wake_pkg::REG_INT_AND: o_read_data <= and_mask[1];
                irq_wake_pkg::REG_ATL_AND: o_read_data <= and_mask[2];
                irq_wake_pkg::REG_ATL_TIMEOUT: o_read_data <= atl_timeout;
                irq_wake_pkg::REG_EDGE_COUNT: o_read_data <= edge_count;
                irq_wake_pkg::REG_POWER_DOWN: o_read_data <= power_down;
                default: o_read_data <= 32'h0000_0000;
            endcase
        end else begin
            o_read_data <= 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Done map masking
    // ----------------------------------------
    logic [2:0] cat_cond, cat_prev, cat_rise;
    logic slow_tick, atl_fire, atl_held;
    logic [9:0] slow_div;
    logic [15:0] atl_timer;
    logic clocks_ready_event;

    always_comb begin
        done_map[0] = i_done.iso;
        done_map[1] = i_done.intr;
        done_map[2] = i_done.async_transfer_list;
    end

    for (genvar c = 0; c < 3; c++) begin : g_cat
        // OR hit wins outright; AND needs the whole selected group done
        assign cat_cond[c] = (|(done_map[c] & or_mask[c]))
            || (and_mask[c] != 32'h0000_0000 && (done_map[c] & and_mask[c]) == and_mask[c]);
    end

    assign cat_rise = cat_cond & ~cat_prev;

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            cat_prev <= 3'h0;
        end else begin
            cat_prev <= cat_cond;
        end
    end

    // Free-running slow tick; never gated, so wake logic sees it in suspend
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            slow_div <= 10'h000;
        end else if (slow_tick) begin
            slow_div <= 10'h000;
        end else begin
            slow_div <= slow_div + 10'h001;
        end
    end
    assign slow_tick = slow_div == 10'(irq_wake_pkg::SLOW_TICK_CYCLES - 1);

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            atl_timer <= 16'h0000;
        end else if (atl_timeout[15:0] == 16'h0000 || atl_fire) begin
            atl_timer <= 16'h0000;
        end else if (slow_tick) begin
            atl_timer <= atl_timer + 16'h0001;
        end
    end
    assign atl_fire = slow_tick && atl_timeout[15:0] != 16'h0000
        && atl_timer == atl_timeout[15:0] - 16'h0001;

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            atl_held <= 1'b0;
        end else if (atl_fire) begin
            atl_held <= 1'b0;
        end else if (cat_rise[2] && atl_timeout[15:0] != 16'h0000) begin
            atl_held <= 1'b1;
        end
    end

    always_comb begin
        set_vec = i_events;
        set_vec[irq_wake_pkg::ST_ISO_DONE] = i_events[irq_wake_pkg::ST_ISO_DONE] | cat_rise[0];
        set_vec[irq_wake_pkg::ST_INT_DONE] = i_events[irq_wake_pkg::ST_INT_DONE] | cat_rise[1];
        set_vec[irq_wake_pkg::ST_ATL_DONE] = i_events[irq_wake_pkg::ST_ATL_DONE]
            | (atl_timeout[15:0] == 16'h0000 ? cat_rise[2] : (atl_fire && (atl_held || cat_rise[2])));
        set_vec[irq_wake_pkg::ST_CLOCKS_READY] = i_events[irq_wake_pkg::ST_CLOCKS_READY] | clocks_ready_event;
    end

    // ----------------------------------------
    // Request output
    // ----------------------------------------
    irq_wake_pkg::irq_state_t irq_state;
    logic [17:0] irq_count, pulse_cycles, gap_cycles;
    logic irq_edge, edge_req, pending, global_on, irq_active;

    assign global_on = hw_mode[irq_wake_pkg::GLOBAL_BIT];
    assign pending = |(status & enable);
    assign pulse_cycles = 18'(({2'b00, edge_count[irq_wake_pkg::PULSE_LSB +: 16]} + 18'h00001)
        * 18'(irq_wake_pkg::PULSE_UNIT_CYCLES));
    assign gap_cycles = 18'(edge_count[irq_wake_pkg::GAP_LSB +: 8]) * 18'(irq_wake_pkg::GAP_UNIT_CYCLES);

    // New enabled events collapse into one waiting flag
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            edge_req <= 1'b0;
        end else if (|(set_vec & enable) && hw_mode[irq_wake_pkg::TRIGGER_BIT]) begin
            edge_req <= 1'b1;
        end else if (irq_state == irq_wake_pkg::IRQ_IDLE && global_on) begin
            edge_req <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            irq_state <= irq_wake_pkg::IRQ_IDLE;
            irq_count <= 18'h00000;
            irq_edge <= 1'b0;
        end else begin
            unique case (irq_state)
                irq_wake_pkg::IRQ_IDLE: begin
                    irq_edge <= hw_mode[irq_wake_pkg::TRIGGER_BIT];
                    irq_count <= pulse_cycles - 18'h00001;
                    if (global_on && (hw_mode[irq_wake_pkg::TRIGGER_BIT] ? edge_req : pending)) begin
                        irq_state <= irq_wake_pkg::IRQ_ACTIVE;
                    end
                end
                irq_wake_pkg::IRQ_ACTIVE: begin
                    // Pulse ignores status writes; level drops when pending clears, global enable goes off or trigger mode is set
                    if (irq_edge ? irq_count == 18'h00000
                        : !(global_on && pending && !hw_mode[irq_wake_pkg::TRIGGER_BIT])) begin
                        irq_state <= gap_cycles == 18'h00000
                            ? irq_wake_pkg::IRQ_IDLE : irq_wake_pkg::IRQ_GAP;
                        irq_count <= gap_cycles - 18'h00001;
                    end else if (irq_edge) begin
                        irq_count <= irq_count - 18'h00001;
                    end
                end
                irq_wake_pkg::IRQ_GAP: begin
                    // Events here only hold edge_req, so they merge into one request
                    if (irq_count == 18'h00000) begin
                        irq_state <= irq_wake_pkg::IRQ_IDLE;
                    end else begin
                        irq_count <= irq_count - 18'h00001;
                    end
                end
            endcase
        end
    end

    assign irq_active = irq_state == irq_wake_pkg::IRQ_ACTIVE && global_on;
    assign o_irq = irq_active ^ ~hw_mode[irq_wake_pkg::POLARITY_BIT];

    // ----------------------------------------
    // Suspend and wake
    // ----------------------------------------
    irq_wake_pkg::power_state_t pwr_state;
    logic [15:0] pwr_count;

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            pwr_state <= irq_wake_pkg::PWR_AWAKE;
            pwr_count <= 16'h0000;
            clocks_ready_event <= 1'b0;
        end else begin
            clocks_ready_event <= 1'b0;
            unique case (pwr_state)
                irq_wake_pkg::PWR_AWAKE: begin
                    if (i_suspend_request) begin
                        pwr_state <= irq_wake_pkg::PWR_SUSPEND;
                    end
                end
                irq_wake_pkg::PWR_SUSPEND: begin
                    // Restart count stands in for the main clocks settling
                    pwr_count <= 16'(irq_wake_pkg::CLOCK_RESTART_CYCLES - 1);
                    if (i_port_change || i_chip_select || !i_wake_pin) begin
                        pwr_state <= irq_wake_pkg::PWR_RESTART;
                    end
                end
                irq_wake_pkg::PWR_RESTART: begin
                    if (pwr_count == 16'h0000) begin
                        pwr_state <= irq_wake_pkg::PWR_RESUME;
                        clocks_ready_event <= 1'b1;
                        pwr_count <= power_down[irq_wake_pkg::CLOCKOFF_LSB +: 16];
                    end else begin
                        pwr_count <= pwr_count - 16'h0001;
                    end
                end
                irq_wake_pkg::PWR_RESUME: begin
                    // Clock-off count is in slow ticks, so resume lasts count plus one ticks
                    if (i_run_stop) begin
                        pwr_state <= irq_wake_pkg::PWR_AWAKE;
                    end else if (slow_tick) begin
                        if (pwr_count == 16'h0000) begin
                            pwr_state <= irq_wake_pkg::PWR_SUSPEND;
                        end else begin
                            pwr_count <= pwr_count - 16'h0001;
                        end
                    end
                end
            endcase
        end
    end

    // Request logic sits on the always-on clock, so it works in suspend
    assign o_main_clocks_on = pwr_state == irq_wake_pkg::PWR_AWAKE
        || pwr_state == irq_wake_pkg::PWR_RESUME;
    assign o_wake_pin = 1'b0;
    assign o_wake_pin_oe = pwr_state != irq_wake_pkg::PWR_SUSPEND;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    // Shortest pulse: a zero width field gives one pulse unit of cycles
    sequence s_pulse_start;
        irq_state == irq_wake_pkg::IRQ_IDLE && global_on && hw_mode[irq_wake_pkg::TRIGGER_BIT] && edge_req
            && edge_count[irq_wake_pkg::PULSE_LSB +: 16] == 16'h0000;
    endsequence

    sequence s_pulse_body;
        (irq_state == irq_wake_pkg::IRQ_ACTIVE)[*3] ##1 irq_state != irq_wake_pkg::IRQ_ACTIVE;
    endsequence

    // A pulse may outlive its status bits; a level request lags its clear by one cycle
    a_irq_needs_global: assert property (irq_active |-> global_on && (irq_edge || $past(pending)))
        else $error("Request active without global enable");

    a_pulse_length: assert property (s_pulse_start |=> s_pulse_body)
        else $error("Edge pulse length wrong");

    a_idle_polarity: assert property (irq_state != irq_wake_pkg::IRQ_ACTIVE
        |-> o_irq == !hw_mode[irq_wake_pkg::POLARITY_BIT])
        else $error("Idle request level wrong");

    a_reset_default: assert property ($rose(i_rstn) |-> !hw_mode[irq_wake_pkg::TRIGGER_BIT] && o_irq)
        else $error("Reset trigger mode not level active low");

    a_set_wins: assert property (i_events != 32'h0000_0000
        |=> (status & $past(i_events)) == $past(i_events))
        else $error("Status event lost");

    a_clear_one: assert property (wr_status
        |=> (status & $past(i_bus.write_data) & ~$past(set_vec)) == 32'h0000_0000)
        else $error("Status bit not cleared");

    a_no_pending: assert property (irq_state == irq_wake_pkg::IRQ_IDLE && !pending && !edge_req
        |=> irq_state != irq_wake_pkg::IRQ_ACTIVE)
        else $error("Request without enabled event");

    a_level_hold: assert property (irq_state == irq_wake_pkg::IRQ_ACTIVE && !irq_edge
        && !hw_mode[irq_wake_pkg::TRIGGER_BIT] && global_on && pending |=> irq_state == irq_wake_pkg::IRQ_ACTIVE)
        else $error("Level request dropped early");

    a_iso_or_hit: assert property ($rose(cat_cond[0]) |-> ##[0:1] status[irq_wake_pkg::ST_ISO_DONE])
        else $error("Category done not flagged");

    a_wake_pin: assert property (pwr_state == irq_wake_pkg::PWR_SUSPEND
        |-> !o_wake_pin_oe && !o_main_clocks_on)
        else $error("Wake pin driven in suspend");

    a_wake_start: assert property (pwr_state == irq_wake_pkg::PWR_SUSPEND && !i_wake_pin
        |=> pwr_state == irq_wake_pkg::PWR_RESTART)
        else $error("Wake pin low did not resume");

    a_clocks_ready: assert property (pwr_state == irq_wake_pkg::PWR_RESTART && pwr_count == 16'h0000
        |=> pwr_state == irq_wake_pkg::PWR_RESUME ##1 status[irq_wake_pkg::ST_CLOCKS_READY])
        else $error("Clocks ready not flagged");

    a_run_keeps: assert property (pwr_state == irq_wake_pkg::PWR_RESUME && i_run_stop
        |=> pwr_state == irq_wake_pkg::PWR_AWAKE)
        else $error("Run bit did not end resume");
endmodule : irq_and_wake_control

// ### irq_wake_pkg.sv
package irq_wake_pkg;
    localparam int CLOCK_NS = 10;
    localparam int CLOCK_HZ = 100_000_000;

    // Register offsets
    localparam logic [15:0] REG_ISO_DONE = 16'h0130;
    localparam logic [15:0] REG_INT_DONE = 16'h0140;
    localparam logic [15:0] REG_ATL_DONE = 16'h0150;
    localparam logic [15:0] REG_HW_MODE = 16'h0300;
    localparam logic [15:0] REG_STATUS = 16'h0310;
    localparam logic [15:0] REG_ENABLE = 16'h0314;
    localparam logic [15:0] REG_ISO_OR = 16'h0318;
    localparam logic [15:0] REG_INT_OR = 16'h031c;
    localparam logic [15:0] REG_ATL_OR = 16'h0320;
    localparam logic [15:0] REG_ISO_AND = 16'h0324;
    localparam logic [15:0] REG_INT_AND = 16'h0328;
    localparam logic [15:0] REG_ATL_AND = 16'h032c;
    localparam logic [15:0] REG_ATL_TIMEOUT = 16'h0338;
    localparam logic [15:0] REG_EDGE_COUNT = 16'h0340;
    localparam logic [15:0] REG_POWER_DOWN = 16'h0354;

    // Reset values
    localparam logic [31:0] HW_MODE_RESET = 32'h0000_0100;
    localparam logic [31:0] EDGE_COUNT_RESET = 32'h0000_000f;
    localparam logic [31:0] POWER_DOWN_RESET = 32'h03e8_1ba0;

    // Field positions
    localparam int GLOBAL_BIT = 0;
    localparam int TRIGGER_BIT = 1;
    localparam int POLARITY_BIT = 2;
    localparam int PULSE_LSB = 0;
    localparam int GAP_LSB = 24;
    localparam int CLOCKOFF_LSB = 16;
    localparam int ST_CLOCKS_READY = 6;
    localparam int ST_INT_DONE = 7;
    localparam int ST_ATL_DONE = 8;
    localparam int ST_ISO_DONE = 9;

    // Timing
    localparam int PULSE_DEFAULT_NS = 500;
    localparam int PULSE_UNIT_CYCLES = PULSE_DEFAULT_NS / ((EDGE_COUNT_RESET[15:0] + 1) * CLOCK_NS);
    localparam int GAP_UNIT_NS = 1000;
    localparam int GAP_UNIT_CYCLES = GAP_UNIT_NS / CLOCK_NS;
    localparam int SLOW_CLOCK_HZ = 100_000;
    localparam int SLOW_TICK_CYCLES = CLOCK_HZ / SLOW_CLOCK_HZ;
    localparam int CLOCK_RESTART_NS = 10_000;
    localparam int CLOCK_RESTART_CYCLES = CLOCK_RESTART_NS / CLOCK_NS;

    typedef struct packed {
        logic [15:0] address;
        logic [31:0] write_data;
        logic write;
        logic read;
    } reg_req_t;

    typedef struct packed {
        logic [31:0] iso;
        logic [31:0] intr;
        logic [31:0] async_transfer_list;
    } done_maps_t;

    typedef enum {PWR_AWAKE, PWR_SUSPEND, PWR_RESTART, PWR_RESUME} power_state_t;
    typedef enum {IRQ_IDLE, IRQ_ACTIVE, IRQ_GAP} irq_state_t;
endpackage : irq_wake_pkg

// ### tb_irq_and_wake_control.sv
`timescale 1ns/1ps
module tb_irq_and_wake_control;
    // ----------------------------------------
    // Stimulus and wiring
    // ----------------------------------------
    logic clock = 1'b0;
    logic rstn = 1'b0;
    irq_wake_pkg::reg_req_t bus = '0;
    irq_wake_pkg::done_maps_t done = '0;
    logic [31:0] events = 32'h0;
    logic port_change = 1'b0;
    logic chip_sel = 1'b0;
    logic run = 1'b0;
    logic sus_req = 1'b0;
    logic gpio_low = 1'b0;
    logic pol_high = 1'b0;
    logic [31:0] rdata;
    logic pin_out;
    logic pin_oe;
    logic clk_on;
    logic irq;
    logic pin_lvl;
    logic seen;
    logic seen_q = 1'b0;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    int act = 0;
    int rises = 0;
    int quiet = 0;
    int gap_seen = 0;
    int a0;
    int r0;
    int c;
    logic [31:0] v;
    logic [31:0] m;
    logic [31:0] m2;

    always #5 clock = ~clock;

    irq_and_wake_control i_irq_and_wake_control (.i_clock(clock), .i_rstn(rstn), .i_bus(bus),
        .o_read_data(rdata), .i_events(events), .i_done(done), .i_port_change(port_change),
        .i_chip_select(chip_sel), .i_run_stop(run), .i_suspend_request(sus_req), .i_wake_pin(pin_lvl),
        .o_wake_pin(pin_out), .o_wake_pin_oe(pin_oe), .o_main_clocks_on(clk_on), .o_irq(irq));
    host_side_model i_host_side_model (.i_irq(irq), .i_pol_high(pol_high), .i_gpio_low(gpio_low),
        .i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_pin_level(pin_lvl), .o_irq_seen(seen));

    // Sampled mid-cycle so the count never races the request flops
    always @(negedge clock) begin
        cycles <= cycles + 1;
        seen_q <= seen;
        quiet <= (seen === 1'b1) ? 0 : quiet + 1;
        if (seen === 1'b1) act <= act + 1;
        if (seen === 1'b1 && seen_q !== 1'b1) begin
            rises <= rises + 1;
            gap_seen <= quiet;
        end
        if (cycles == 40000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_bit
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clock);
        bus <= '{address: a, write_data: d, write: 1'b1, read: 1'b0};
        @(posedge clock);
        bus <= '0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge clock);
        bus <= '{address: a, write_data: 32'h0, write: 1'b0, read: 1'b1};
        @(posedge clock);
        bus <= '0;
        #1 d = rdata;
    endtask : rd
    task automatic st(input logic [31:0] msk, input logic [31:0] exp);
        rd(irq_wake_pkg::REG_STATUS, v);
        chk_word(v & msk, exp);
    endtask : st
    task automatic fire(input logic [31:0] b);
        @(posedge clock);
        events <= b;
        @(posedge clock);
        events <= 32'h0;
    endtask : fire
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic wake_wait();
        c = 0;
        while (clk_on !== 1'b1 && c < 1500) begin
            tick(1);
            c++;
        end
    endtask : wake_wait
    task automatic suspend();
        @(posedge clock);
        sus_req <= 1'b1;
        @(posedge clock);
        sus_req <= 1'b0;
        tick(2);
    endtask : suspend
    function automatic logic [31:0] width_of(input logic [15:0] f);
        return ({16'h0, f} + 32'h1) * irq_wake_pkg::PULSE_UNIT_CYCLES;
    endfunction : width_of
    task automatic tally_and_finish();
        if (num_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        v = $urandom(89720);
        m = 32'h1 << $urandom_range(31, 10);
        m2 = (m == 32'h8000_0000) ? 32'h400 : m << 1;
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        tick(1);
        chk_bit(irq, 1'b1);
        chk_bit(pin_lvl, 1'b0);
        rd(irq_wake_pkg::REG_HW_MODE, v);
        chk_word(v & 32'h7, 32'h0);
        rd(irq_wake_pkg::REG_POWER_DOWN, v);
        chk_word(v, irq_wake_pkg::POWER_DOWN_RESET);
        rd(16'h0304, v);
        chk_word(v, 32'h0);
        wr(irq_wake_pkg::REG_HW_MODE, 32'h101);
        fire(m);
        tick(4);
        chk_bit(seen, 1'b0);
        st(m, m);
        wr(irq_wake_pkg::REG_STATUS, 32'h0);
        st(m, m);
        wr(irq_wake_pkg::REG_STATUS, 32'hffff_ffff);
        st(m, 32'h0);
        wr(irq_wake_pkg::REG_ENABLE, 32'hffff_ffc0);
        wr(irq_wake_pkg::REG_HW_MODE, 32'h100);
        fire(m);
        tick(4);
        chk_bit(seen, 1'b0);
        wr(irq_wake_pkg::REG_HW_MODE, 32'h101);
        tick(3);
        chk_bit(irq, 1'b0);
        tick(20);
        chk_bit(seen, 1'b1);
        wr(irq_wake_pkg::REG_STATUS, m);
        tick(2);
        chk_bit(seen, 1'b0);
        wr(irq_wake_pkg::REG_HW_MODE, 32'h105);
        pol_high <= 1'b1;
        fire(m);
        tick(3);
        chk_bit(irq, 1'b1);
        wr(irq_wake_pkg::REG_STATUS, m);
        wr(irq_wake_pkg::REG_HW_MODE, 32'h107);
        for (int i = 0; i < 2; i++) begin
            v = (i == 0) ? irq_wake_pkg::EDGE_COUNT_RESET : $urandom_range(20, 1);
            if (i > 0) wr(irq_wake_pkg::REG_EDGE_COUNT, v);
            a0 = act;
            r0 = rises;
            fire(m);
            wr(irq_wake_pkg::REG_STATUS, m);
            tick(100);
            chk_word(32'(act - a0), width_of(v[15:0]));
            chk_word(32'(rises - r0), 32'h1);
        end
        // Spacing of one microsecond with a short pulse; later events must merge
        wr(irq_wake_pkg::REG_EDGE_COUNT, 32'h0100_0000);
        r0 = rises;
        fire(m);
        fire(m2);
        wr(irq_wake_pkg::REG_STATUS, m | m2);
        tick(20);
        fire(m);
        tick(300);
        chk_word(32'(rises - r0), 32'h2);
        chk_bit(gap_seen >= irq_wake_pkg::GAP_UNIT_CYCLES, 1'b1);
        wr(irq_wake_pkg::REG_EDGE_COUNT, 32'h0);
        wr(irq_wake_pkg::REG_STATUS, 32'hffff_ffff);
        wr(irq_wake_pkg::REG_HW_MODE, 32'h101);
        pol_high <= 1'b0;
        v = 32'h1 << $urandom_range(31, 0);
        wr(irq_wake_pkg::REG_ISO_OR, v);
        done.iso <= v;
        tick(4);
        chk_bit(seen, 1'b1);
        st(32'h200, 32'h200);
        rd(irq_wake_pkg::REG_ISO_DONE, m2);
        chk_word(m2, done.iso);
        done.iso <= 32'h0;
        wr(irq_wake_pkg::REG_STATUS, 32'h200);
        wr(irq_wake_pkg::REG_INT_AND, 32'h16);
        done.intr <= 32'h6 | ($urandom() & 32'hffff_ffe9);
        tick(4);
        st(32'h80, 32'h0);
        done.intr <= done.intr | 32'h10;
        tick(4);
        st(32'h80, 32'h80);
        // Bulk hold of three slow ticks is at least two ticks whatever the phase
        wr(irq_wake_pkg::REG_ATL_TIMEOUT, 32'h3);
        wr(irq_wake_pkg::REG_ATL_OR, 32'h1);
        done.async_transfer_list <= 32'h1;
        tick(20);
        st(32'h100, 32'h0);
        tick(3100);
        st(32'h100, 32'h100);
        done <= '0;
        wr(irq_wake_pkg::REG_STATUS, 32'hffff_ffff);
        wr(irq_wake_pkg::REG_POWER_DOWN, 32'h0002_1ba0);
        suspend();
        chk_bit(pin_oe, 1'b0);
        chk_bit(clk_on, 1'b0);
        chk_bit(pin_lvl, 1'b1);
        fire(m);
        tick(4);
        chk_bit(seen, 1'b1);
        gpio_low <= 1'b1;
        wake_wait();
        gpio_low <= 1'b0;
        chk_bit(clk_on, 1'b1);
        st(32'h40, 32'h40);
        run <= 1'b1;
        wr(irq_wake_pkg::REG_STATUS, 32'hffff_ffff);
        tick(4000);
        chk_bit(pin_lvl, 1'b0);
        run <= 1'b0;
        suspend();
        @(posedge clock);
        chip_sel <= 1'b1;
        @(posedge clock);
        chip_sel <= 1'b0;
        wake_wait();
        chk_bit(clk_on, 1'b1);
        tick(1500);
        chk_bit(clk_on, 1'b1);
        tick(2600);
        chk_bit(pin_oe, 1'b0);
        @(posedge clock);
        port_change <= 1'b1;
        @(posedge clock);
        port_change <= 1'b0;
        wake_wait();
        chk_bit(clk_on, 1'b1);
        tally_and_finish();
    end
endmodule : tb_irq_and_wake_control
